// >>> inc/dio_pkg.sv
// shared constants for the ddr-capable i/o block
package dio_pkg;
	localparam int NUM_ELEM = 6;
	localparam int NUM_ROW_ELEM = 4;
	localparam int NUM_ROUTED = 4;
	localparam int ADDR_W = 8;

	// element transfer modes
	typedef enum logic [1:0]
	{
		MODE_SDR = 2'b00,
		MODE_DDR_IN = 2'b01,
		MODE_DDR_OUT = 2'b10,
		MODE_DDR_BIDIR = 2'b11
	} dio_mode_t;

	// axi write response states
	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_RESP = 2'b01
	} dio_bus_t;

	// register byte offsets
	localparam logic [7:0] OFS_PIN_STATUS = 8'h00;
	localparam logic [7:0] OFS_CAPTURE = 8'h04;
	localparam logic [7:0] OFS_CFG_BASE = 8'h10;
	localparam logic [7:0] OFS_INV_BASE = 8'h30;

	// configuration word fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_CLR_PRESET = 2;
	localparam int CFG_PWRUP_HIGH = 3;
	localparam int CFG_OE_ACT_LOW = 4;
	localparam int CFG_OE_SEL = 8;
	localparam int CFG_CEIN_SEL = 11;
	localparam int CFG_CEOUT_SEL = 14;
	localparam int CFG_CLR_SEL = 17;
	localparam int CFG_SCLR_SEL = 20;
	localparam int CFG_CLKIN_SEL = 23;
	localparam int CFG_CLKOUT_SEL = 26;
	localparam int SEL_W = 3;

	// select codes: 0..3 routed lines, then own fabric line, tied high, tied low
	localparam logic [2:0] SEL_OWN = 3'h4;
	localparam logic [2:0] SEL_ONE = 3'h5;

	// inversion word fields
	localparam int INV_OE = 0;
	localparam int INV_CEIN = 1;
	localparam int INV_CEOUT = 2;
	localparam int INV_CLR = 3;
	localparam int INV_SCLR = 4;
	localparam int INV_CLKIN = 5;
	localparam int INV_CLKOUT = 6;
	localparam int INV_DATA_A = 7;
	localparam int INV_DATA_B = 8;
	localparam int INV_PIN = 9;
	localparam int INV_W = 10;

	// values after reset
	localparam logic [31:0] CFG_RST = 32'h16FF_6C00;
	localparam logic [9:0] INV_RST = 10'h000;

	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> design/dio_sync2.sv
// two-flop level synchroniser for a pin read back by software
`timescale 1ns/1ps
module dio_sync2
(
	input wire logic clk,
	input wire logic rst,
	input wire logic async,
	output logic sync
);
	import dio_pkg::*;
	logic stage1;

	// stage1 feeds only the second flop
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stage1 <= 1'b0;
			sync <= 1'b0;
		end
		else
		begin
			stage1 <= async;
			sync <= stage1;
		end
	end
endmodule // dio_sync2

// >>> design/dio_elem.sv
// one i/o element: two capture flops plus latch, two output flops, two enable flops
`timescale 1ns/1ps
module dio_elem
(
	input wire logic clk,
	input wire logic rst,
	input wire dio_pkg::dio_mode_t mode,
	input wire logic clrIsPreset,
	input wire logic pwrUpHigh,
	input wire logic clrAct,
	input wire logic sclrAct,
	input wire logic ceIn,
	input wire logic ceOut,
	input wire logic clkInTick,
	input wire logic clkOutTick,
	input wire logic oeReq,
	input wire logic dataA,
	input wire logic dataB,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe_n,
	output logic capRise,
	output logic capFall
);
	import dio_pkg::*;

	logic riseQ;
	logic fallQ;
	logic latchQ;
	logic outA;
	logic outB;
	logic oePos;
	logic oeNeg;

	// decoded mode and update strobes
	wire ddrIn = (mode == MODE_DDR_IN) || (mode == MODE_DDR_BIDIR);
	wire ddrOut = (mode == MODE_DDR_OUT) || (mode == MODE_DDR_BIDIR);
	wire isInput = (mode == MODE_DDR_IN);
	wire clrVal = clrIsPreset;
	wire anyClr = clrAct | sclrAct;
	wire updIn = clkInTick & ceIn;
	wire updOut = clkOutTick & ceOut;

	// rising-edge capture; holds when the input enable is low
	always_ff @(posedge clk)
	begin
		if (rst)
			riseQ <= pwrUpHigh;
		else if (anyClr)
			riseQ <= clrVal;
		else if (updIn)
			riseQ <= pinIn;
	end

	// falling-edge capture used only for double-rate input
	always_ff @(negedge clk)
	begin
		if (rst)
			fallQ <= pwrUpHigh;
		else if (anyClr)
			fallQ <= clrVal;
		else if (updIn & ddrIn)
			fallQ <= pinIn;
	end

	// open while the clock is low, holds through the high time
	always_latch
	begin
		if (!clk)
			latchQ <= fallQ;
	end

	// both output paths load on the rising edge
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			outA <= pwrUpHigh;
			outB <= pwrUpHigh;
			oePos <= pwrUpHigh;
		end
		else if (anyClr)
		begin
			outA <= clrVal;
			outB <= clrVal;
			oePos <= clrVal;
		end
		else if (updOut)
		begin
			outA <= dataA;
			outB <= dataB;
			oePos <= oeReq;
		end
	end

	// second enable stage delays driver turn-on to the next falling edge
	always_ff @(negedge clk)
	begin
		if (rst)
			oeNeg <= pwrUpHigh;
		else if (anyClr)
			oeNeg <= clrVal;
		else
			oeNeg <= oePos;
	end

	// clear acts at once on the outputs, not waiting for an edge
	wire aEff = clrAct ? clrVal : outA;
	wire bEff = clrAct ? clrVal : outB;
	wire oePosEff = clrAct ? clrVal : oePos;
	wire oeNegEff = clrAct ? clrVal : oeNeg;
	wire drive = isInput ? 1'b0 :
		(mode == MODE_DDR_BIDIR) ? (oePosEff & oeNegEff) : oePosEff;

	assign pinOut = ddrOut ? (clk ? aEff : bEff) : aEff;
	assign pinOe_n = ~drive;
	assign capRise = clrAct ? clrVal : riseQ;
	assign capFall = clrAct ? clrVal : latchQ;
endmodule // dio_elem

// >>> design/dio_col_block.sv
// column i/o block of six ddr-capable elements with an axi4-lite config port
// How it works
// - each element has capture flops and latch, output and enable flops.
// - double-rate input samples the pin on rising and on falling edges.
// - a latch holds the falling bit so both bits align to one edge.
// - double-rate output loads both data paths on the rising edge.
// - pin shows first bit while clock high, second while clock low.
// - bidirectional mode delays driver turn-on to the next falling edge.
// - input capture has its own clock and enable selection.
// - output and enable flops share one clock and one enable choice.
// - each element picks its own control lines from routed sources.
// - every incoming fabric signal has a programmable inversion.
// - two clear sources per element, asynchronous and synchronous, each acting as clear or preset.
// - registers start at a programmable level set apart from clear or preset.
// - a synchronous clear acts only on the active clock edge.
// - sixteen routed lines: four enables, clock enables, clocks, clears.
// - a column block holds six elements feeding column routing only.
// - twelve data-out lines, a pair per element.
// - driver enable is active high unless set to active low.
// - output flops hold their value while the output clock enable is low.
`timescale 1ns/1ps
module dio_col_block
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [dio_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dio_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [dio_pkg::NUM_ROUTED-1:0] blockOe,
	input wire logic [dio_pkg::NUM_ROUTED-1:0] blockCe,
	input wire logic [dio_pkg::NUM_ROUTED-1:0] blockClk,
	input wire logic [dio_pkg::NUM_ROUTED-1:0] blockClr,
	input wire logic [dio_pkg::NUM_ELEM-1:0] elemOe,
	input wire logic [dio_pkg::NUM_ELEM-1:0] elemCeIn,
	input wire logic [dio_pkg::NUM_ELEM-1:0] elemCeOut,
	input wire logic [dio_pkg::NUM_ELEM-1:0] elemClk,
	input wire logic [dio_pkg::NUM_ELEM-1:0] elemClr,
	input wire logic [dio_pkg::NUM_ELEM-1:0] dataOutA,
	input wire logic [dio_pkg::NUM_ELEM-1:0] dataOutB,
	input wire logic [dio_pkg::NUM_ELEM-1:0] pinIn,
	output logic [dio_pkg::NUM_ELEM-1:0] pinOut,
	output logic [dio_pkg::NUM_ELEM-1:0] pinOe_n,
	output logic [dio_pkg::NUM_ELEM-1:0] dataInRise,
	output logic [dio_pkg::NUM_ELEM-1:0] dataInFall
);
	import dio_pkg::*;

	// picks one routed line, the element's own line, or a tie level
	function automatic logic pickLine(input logic [2:0] sel, input logic [3:0] routed,
		input logic own);
		logic r;
		r = 1'b0;
		case (sel)
			3'h0, 3'h1, 3'h2, 3'h3: r = routed[sel[1:0]];
			SEL_OWN: r = own;
			SEL_ONE: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// element index of a register in a bank, or NUM_ELEM when outside it
	function automatic logic [2:0] bankIndex(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] diff;
		diff = addr - base;
		if (addr >= base && diff[7:2] < 6'(NUM_ELEM) && diff[1:0] == 2'b00)
			return diff[4:2];
		else
			return 3'(NUM_ELEM);
	endfunction

	logic [31:0] cfg [NUM_ELEM];
	logic [INV_W-1:0] inv [NUM_ELEM];
	logic [NUM_ELEM-1:0] pinSync;
	logic [ADDR_W-1:0] awAddrQ;
	logic [31:0] wDataQ;
	logic [3:0] wStrbQ;
	logic awHave;
	logic wHave;
	dio_bus_t wrState;
	logic [31:0] rdDataQ;
	logic [1:0] rdRespQ;

	// ---------------- write channel ----------------
	// address and data are taken in either order and held until both are in
	assign s_axi_awready = !awHave && (wrState == BUS_IDLE);
	assign s_axi_wready = !wHave && (wrState == BUS_IDLE);

	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake = s_axi_wvalid && s_axi_wready;
	wire [ADDR_W-1:0] wrAddr = awTake ? s_axi_awaddr : awAddrQ;
	wire [31:0] wrData = wTake ? s_axi_wdata : wDataQ;
	wire [3:0] wrStrb = wTake ? s_axi_wstrb : wStrbQ;
	wire wrGo = (wrState == BUS_IDLE) && (awHave || awTake) && (wHave || wTake);
	wire [2:0] wrCfgIdx = bankIndex(wrAddr, OFS_CFG_BASE);
	wire [2:0] wrInvIdx = bankIndex(wrAddr, OFS_INV_BASE);
	wire wrCfgHit = wrCfgIdx != 3'(NUM_ELEM);
	wire wrInvHit = wrInvIdx != 3'(NUM_ELEM);
	wire wrStatusHit = (wrAddr == OFS_PIN_STATUS) || (wrAddr == OFS_CAPTURE);

	// holding registers for an early address or data beat
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			awHave <= 1'b0;
			wHave <= 1'b0;
			awAddrQ <= '0;
			wDataQ <= '0;
			wStrbQ <= '0;
		end
		else
		begin
			if (awTake)
				awAddrQ <= s_axi_awaddr;
			if (wTake)
			begin
				wDataQ <= s_axi_wdata;
				wStrbQ <= s_axi_wstrb;
			end
			awHave <= wrGo ? 1'b0 : (awHave | awTake);
			wHave <= wrGo ? 1'b0 : (wHave | wTake);
		end
	end

	// response state: unmapped writes answer slverr, status words are read-only
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wrState <= BUS_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			case (wrState)
				BUS_IDLE:
				begin
					if (wrGo)
					begin
						wrState <= BUS_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= (wrCfgHit || wrInvHit || wrStatusHit) ?
							RESP_OKAY : RESP_SLVERR;
					end
				end
				BUS_RESP:
				begin
					if (s_axi_bready)
					begin
						wrState <= BUS_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: wrState <= BUS_IDLE;
			endcase
		end
	end

	// ---------------- configuration store ----------------
	// byte lanes honoured; one word per element in each bank
	genvar g;
	generate
		for (g = 0; g < NUM_ELEM; g++)
		begin : g_cfg
			logic [31:0] cfgMerged;
			logic [31:0] invMerged;
			always_comb
			begin
				cfgMerged = cfg[g];
				invMerged = 32'(inv[g]);
				for (int b = 0; b < 4; b++)
				begin
					if (wrStrb[b])
					begin
						cfgMerged[b*8 +: 8] = wrData[b*8 +: 8];
						invMerged[b*8 +: 8] = wrData[b*8 +: 8];
					end
				end
			end

			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					cfg[g] <= CFG_RST;
					inv[g] <= INV_RST;
				end
				else if (wrGo)
				begin
					if (wrCfgHit && wrCfgIdx == 3'(g))
						cfg[g] <= cfgMerged;
					if (wrInvHit && wrInvIdx == 3'(g))
						inv[g] <= invMerged[INV_W-1:0];
				end
			end
		end
	endgenerate

	// ---------------- read channel ----------------
	wire [2:0] rdCfgIdx = bankIndex(s_axi_araddr, OFS_CFG_BASE);
	wire [2:0] rdInvIdx = bankIndex(s_axi_araddr, OFS_INV_BASE);
	wire [31:0] pinWord = {26'h0, pinSync};
	wire [31:0] capWord = {18'h0, dataInFall, 2'b00, dataInRise};

	// read decode; reserved status, capture and inversion bits read as zero, config words read back all 32 stored bits
	always_comb
	begin
		rdDataQ = 32'h0000_0000;
		rdRespQ = RESP_OKAY;
		if (s_axi_araddr == OFS_PIN_STATUS)
			rdDataQ = pinWord;
		else if (s_axi_araddr == OFS_CAPTURE)
			rdDataQ = capWord;
		else if (rdCfgIdx != 3'(NUM_ELEM))
			rdDataQ = cfg[rdCfgIdx];
		else if (rdInvIdx != 3'(NUM_ELEM))
			rdDataQ = 32'(inv[rdInvIdx]);
		else
			rdRespQ = RESP_SLVERR;
	end

	assign s_axi_arready = !s_axi_rvalid;

	// one read in flight; data is registered at the address handshake
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdDataQ;
			s_axi_rresp <= rdRespQ;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ---------------- the six elements ----------------
	// column block: all captured data go to column routing only
	generate
		for (g = 0; g < NUM_ELEM; g++)
		begin : g_elem
			wire [31:0] c = cfg[g];
			wire [INV_W-1:0] v = inv[g];
			// per-element selection from the sixteen shared lines
			wire oeSel = pickLine(c[CFG_OE_SEL +: SEL_W], blockOe, elemOe[g]);
			wire ceInSel = pickLine(c[CFG_CEIN_SEL +: SEL_W], blockCe, elemCeIn[g]);
			wire ceOutSel = pickLine(c[CFG_CEOUT_SEL +: SEL_W], blockCe, elemCeOut[g]);
			wire clrSel = pickLine(c[CFG_CLR_SEL +: SEL_W], blockClr, elemClr[g]);
			wire sclrSel = pickLine(c[CFG_SCLR_SEL +: SEL_W], blockClr, elemClr[g]);
			wire clkInSel = pickLine(c[CFG_CLKIN_SEL +: SEL_W], blockClk, elemClk[g]);
			wire clkOutSel = pickLine(c[CFG_CLKOUT_SEL +: SEL_W], blockClk, elemClk[g]);
			// inversion at the element boundary
			wire oeInv = oeSel ^ v[INV_OE];
			wire oeUser = c[CFG_OE_ACT_LOW] ? ~oeInv : oeInv;
			// a single clear source reaches every register of the element
			wire clrLine = clrSel ^ v[INV_CLR];

			dio_elem u_elem
			(
				.clk(clk),
				.rst(rst),
				.mode(dio_mode_t'(c[CFG_MODE_LSB +: 2])),
				.clrIsPreset(c[CFG_CLR_PRESET]),
				.pwrUpHigh(c[CFG_PWRUP_HIGH]),
				.clrAct(clrLine),
				.sclrAct(sclrSel ^ v[INV_SCLR]),
				.ceIn(ceInSel ^ v[INV_CEIN]),
				.ceOut(ceOutSel ^ v[INV_CEOUT]),
				.clkInTick(clkInSel ^ v[INV_CLKIN]),
				.clkOutTick(clkOutSel ^ v[INV_CLKOUT]),
				.oeReq(oeUser),
				.dataA(dataOutA[g] ^ v[INV_DATA_A]),
				.dataB(dataOutB[g] ^ v[INV_DATA_B]),
				.pinIn(pinIn[g] ^ v[INV_PIN]),
				.pinOut(pinOut[g]),
				.pinOe_n(pinOe_n[g]),
				.capRise(dataInRise[g]),
				.capFall(dataInFall[g])
			);

			// pin level for software readback only
			dio_sync2 u_sync
			(
				.clk(clk),
				.rst(rst),
				.async(pinIn[g]),
				.sync(pinSync[g])
			);
		end
	endgenerate

	// six elements per column block
endmodule // dio_col_block

// >>> bench/dio_col_props.sv
// checker for element 0 pin timing and bus response holding
`timescale 1ns/1ps
module dio_col_props
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [dio_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [dio_pkg::NUM_ELEM-1:0] elemOe,
	input wire logic [dio_pkg::NUM_ELEM-1:0] dataOutA,
	input wire logic [dio_pkg::NUM_ELEM-1:0] dataOutB,
	input wire logic [dio_pkg::NUM_ELEM-1:0] pinIn,
	input wire logic [dio_pkg::NUM_ELEM-1:0] pinOut,
	input wire logic [dio_pkg::NUM_ELEM-1:0] pinOe_n,
	input wire logic [dio_pkg::NUM_ELEM-1:0] dataInRise,
	input wire logic [dio_pkg::NUM_ELEM-1:0] dataInFall
);
	import dio_pkg::*;
	logic [31:0] cfg0;
	logic [31:0] cfgOld;
	logic aReg;
	logic bReg;
	logic lowOe;
	logic lowFall;
	logic fallPin;
	// element 0 config mirrored from bus writes; checks skip the cycle after a change
	wire plain = cfg0 == cfgOld && cfg0[31:5] == CFG_RST[31:5];
	wire [1:0] md = cfg0[1:0];
	// assumes address and data are offered together, as the bench does
	always_ff @(posedge clk)
	begin
		if (rst)
			cfg0 <= CFG_RST;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == OFS_CFG_BASE)
			cfg0 <= s_axi_wdata;
		cfgOld <= cfg0;
		aReg <= dataOutA[0];
		bReg <= dataOutB[0];
		lowOe <= pinOe_n[0];
		lowFall <= dataInFall[0];
	end
	// pin level just before each falling edge
	always_ff @(negedge clk)
		fallPin <= pinIn[0];
	a_ddr_out_high: assert property (@(negedge clk) disable iff (rst)
		plain && md == MODE_DDR_OUT |-> pinOut[0] == aReg) else $error("high phase bit wrong");
	a_ddr_out_low: assert property (@(posedge clk) disable iff (rst)
		plain && md == MODE_DDR_OUT |-> pinOut[0] == bReg) else $error("low phase bit wrong");
	a_ddr_in_rise: assert property (@(posedge clk) disable iff (rst)
		plain && md == MODE_DDR_IN |=> dataInRise[0] == $past(pinIn[0]))
		else $error("rising capture wrong");
	a_ddr_in_fall: assert property (@(posedge clk) disable iff (rst)
		plain && md == MODE_DDR_IN |-> dataInFall[0] == fallPin)
		else $error("falling capture wrong");
	a_fall_latch_hold: assert property (@(negedge clk) disable iff (rst)
		plain && md == MODE_DDR_IN |-> dataInFall[0] == lowFall)
		else $error("latch moved in high phase");
	a_bidir_turn_on: assert property (@(negedge clk) disable iff (rst)
		plain && md == MODE_DDR_BIDIR && !pinOe_n[0] |-> !lowOe)
		else $error("driver turned on before falling edge");
	a_oe_polarity: assert property (@(posedge clk) disable iff (rst)
		plain && md == MODE_SDR |=> pinOe_n[0] == ($past(elemOe[0]) ~^ $past(cfg0[4])))
		else $error("driver enable polarity wrong");
	a_bresp_hold: assert property (@(posedge clk) disable iff (rst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule // dio_col_props

bind dio_col_block dio_col_props chk (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .elemOe,
	.dataOutA, .dataOutB, .pinIn, .pinOut, .pinOe_n, .dataInRise, .dataInFall);

// >>> bench/dio_ddr_partner.sv
// far-side device on the six pins, resolving the shared wire level
`timescale 1ns/1ps
module dio_ddr_partner
(
	input wire logic clk,
	input wire logic driveEn,
	input wire logic [dio_pkg::NUM_ELEM-1:0] riseData,
	input wire logic [dio_pkg::NUM_ELEM-1:0] fallData,
	input wire logic [dio_pkg::NUM_ELEM-1:0] pinOut,
	input wire logic [dio_pkg::NUM_ELEM-1:0] pinOe_n,
	output logic [dio_pkg::NUM_ELEM-1:0] pinIn
);
	import dio_pkg::*;
	logic [NUM_ELEM-1:0] drv = '0;
	// launched after each edge; once released the lines toggle so stale data never passes
	always @(posedge clk)
		drv <= #2 driveEn ? fallData : ~drv;
	always @(negedge clk)
		drv <= #2 driveEn ? riseData : ~drv;
	// a driving element wins the wire
	assign pinIn = (pinOut & ~pinOe_n) | (drv & pinOe_n);
endmodule // dio_ddr_partner

// >>> bench/dio_col_block_tb_top.sv
// self-checking bench for the column i/o block
`timescale 1ns/1ps
module dio_col_block_tb_top;
	import dio_pkg::*;
	logic clk;
	logic rst;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_wstrb;
	logic [NUM_ROUTED-1:0] blockOe, blockCe, blockClk, blockClr;
	logic [NUM_ELEM-1:0] elemOe, elemCeIn, elemCeOut, elemClk, elemClr, dataOutA, dataOutB;
	logic [NUM_ELEM-1:0] pinIn, pinOut, pinOe_n, dataInRise, dataInFall, riseData, fallData;
	logic driveEn;
	logic [1:0] wq[$];
	logic [33:0] rq[$];
	int miscompares, n_compared, cyc, i, lag;
	logic [31:0] seed;
	logic [5:0] a, b, prevF;
	dio_col_block uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .blockOe, .blockCe, .blockClk, .blockClr,
		.elemOe, .elemCeIn, .elemCeOut, .elemClk, .elemClr, .dataOutA, .dataOutB, .pinIn,
		.pinOut, .pinOe_n, .dataInRise, .dataInFall);
	dio_ddr_partner mem (.clk, .driveEn, .riseData, .fallData, .pinOut, .pinOe_n, .pinIn);
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic axiWrite(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
		logic ap;
		logic wp;
		ap = 1;
		wp = 1;
		wq.push_back(r);
		@(posedge clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= (lag == 0);
		while (ap || wp)
		begin
			@(posedge clk);
			if (ap && s_axi_awready) s_axi_awvalid <= 0;
			if (wp && s_axi_wready) s_axi_wvalid <= 0;
			ap = ap && !s_axi_awready;
			wp = wp && !s_axi_wready;
		end
		do @(posedge clk); while (!s_axi_bvalid);
		// late ready: the response has to stand until it is taken
		if (lag > 0)
		begin
			repeat (lag) @(posedge clk);
			s_axi_bready <= 1;
			do @(posedge clk); while (!s_axi_bvalid);
		end
		s_axi_bready <= 0;
	endtask
	task automatic axiRead(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		@(posedge clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= (lag == 0);
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge clk); while (!s_axi_rvalid);
		if (lag > 0)
		begin
			repeat (lag) @(posedge clk);
			s_axi_rready <= 1;
			do @(posedge clk); while (!s_axi_rvalid);
		end
		s_axi_rready <= 0;
	endtask
	// set one mode in all six elements
	task allMode(input logic [31:0] m);
		for (i = 0; i < NUM_ELEM; i++)
			axiWrite(OFS_CFG_BASE + 8'(4 * i), CFG_RST | m, RESP_OKAY);
	endtask
	// responses are compared against the oldest note as they are taken
	always @(posedge clk)
	begin
		if (s_axi_bvalid && s_axi_bready) check("bresp", 34'(s_axi_bresp), 34'(wq.pop_front()));
		if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
	end
	// routed oe, clock and clear lines and own ce and clock lines keep toggling; routed ce stays test-driven; also the hang limit
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		{blockOe, blockClk, blockClr, elemCeIn, elemCeOut, elemClk} <= 30'(cyc * 32'h9E37);
		if (cyc == 6000)
		begin
			miscompares++;
			complete_run();
		end
	end
	initial
	begin
		seed = 32'h2840c9e4;
		{rst, s_axi_wstrb} = 5'h1F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{blockCe, elemOe, elemClr, dataOutA, dataOutB} = '0;
		{riseData, fallData, driveEn} = '0;
		repeat (2) @(posedge clk);
		rst <= 0;
		axiRead(OFS_CFG_BASE, CFG_RST, RESP_OKAY);
		axiRead(OFS_INV_BASE, 32'(INV_RST), RESP_OKAY);
		axiRead(8'hF0, 32'h0, RESP_SLVERR);
		axiWrite(8'hF0, 32'hFFFF_FFFF, RESP_SLVERR);
		// ready held back for two cycles on one read and one write
		lag = 2;
		axiRead(OFS_CFG_BASE + 8'h04, CFG_RST, RESP_OKAY);
		axiWrite(OFS_PIN_STATUS, 32'h0000_0000, RESP_OKAY);
		lag = 0;
		$display("test registers done");
		axiWrite(OFS_INV_BASE + 8'h14, 32'h81, RESP_OKAY);
		axiWrite(OFS_CFG_BASE + 8'h04, CFG_RST | (32'h1 << CFG_OE_ACT_LOW), RESP_OKAY);
		for (i = 0; i < 8; i++)
		begin
			@(posedge clk);
			a = 6'($random(seed));
			b = 6'($random(seed));
			dataOutA <= a;
			elemOe <= b;
			@(posedge clk);
			#2;
			check("sdr pin", 34'(pinOut), 34'(a ^ 6'h20));
			check("sdr enable", 34'(pinOe_n), {28'h0, ~(b ^ 6'h22)});
		end
		$display("test sdr done");
		allMode(32'(MODE_DDR_OUT));
		repeat (8)
		begin
			@(posedge clk);
			a = 6'($random(seed));
			b = 6'($random(seed));
			dataOutA <= a;
			dataOutB <= b;
			@(posedge clk);
			#2;
			check("first bit", 34'(pinOut), 34'(a ^ 6'h20));
			@(negedge clk);
			#2;
			check("second bit", 34'(pinOut), 34'(b));
		end
		$display("test ddr out done");
		allMode(32'(MODE_DDR_IN));
		for (i = 0; i < 8; i++)
		begin
			@(posedge clk);
			a = 6'($random(seed));
			b = 6'($random(seed));
			riseData <= a;
			fallData <= b;
			driveEn <= 1;
			@(posedge clk);
			#2;
			check("rise capture", 34'(dataInRise), 34'(a));
			if (i > 0) check("fall capture", 34'(dataInFall), 34'(prevF));
			check("input only", 34'(pinOe_n), 34'h3F);
			prevF = b;
		end
		axiRead(OFS_CAPTURE, {18'h0, b, 2'b00, a}, RESP_OKAY);
		$display("test ddr in done");
		axiWrite(OFS_INV_BASE + 8'h14, 32'h0, RESP_OKAY);
		allMode(32'(MODE_DDR_BIDIR));
		@(posedge clk);
		driveEn <= 0;
		elemOe <= 6'h00;
		repeat (2) @(posedge clk);
		elemOe <= 6'h3F;
		@(posedge clk);
		#2;
		check("driver held off", 34'(pinOe_n), 34'h3F);
		@(negedge clk);
		#2;
		check("driver on", 34'(pinOe_n), 34'h00);
		$display("test bidir done");
		axiWrite(OFS_CFG_BASE + 8'h08, CFG_RST & ~(32'h3F << CFG_CEIN_SEL), RESP_OKAY);
		axiWrite(OFS_CFG_BASE + 8'h0C, CFG_RST & ~(32'h7 << CFG_CLR_SEL)
			| (32'(SEL_OWN) << CFG_CLR_SEL) | 32'h4, RESP_OKAY);
		@(posedge clk);
		{blockCe, dataOutA, riseData, fallData, elemOe, driveEn} <= {4'hF, 24'h0, 1'b1};
		repeat (2) @(posedge clk);
		{blockCe, dataOutA, riseData, fallData} <= {4'h0, 18'h3FFFF};
		repeat (3) @(posedge clk);
		#2;
		check("output hold", 34'(pinOut[2]), 34'h0);
		check("capture hold", 34'(dataInRise[2]), 34'h0);
		@(posedge clk);
		blockCe <= 4'hF;
		repeat (2) @(posedge clk);
		#2;
		check("output load", 34'(pinOut[2]), 34'h1);
		check("capture load", 34'(dataInRise[2]), 34'h1);
		@(posedge clk);
		{elemClr, dataOutA, riseData, fallData} <= {6'h08, 18'h0};
		@(posedge clk);
		#2;
		check("preset pin", 34'(pinOut[3]), 34'h1);
		check("preset capture", 34'(dataInRise[3]), 34'h1);
		@(posedge clk);
		elemClr <= 6'h00;
		repeat (2) @(posedge clk);
		#2;
		check("preset released", 34'(pinOut[3]), 34'h0);
		// synchronous clear: the pin does not move until the next rising edge
		axiWrite(OFS_CFG_BASE + 8'h0C, CFG_RST & ~(32'h7 << CFG_SCLR_SEL)
			| (32'(SEL_OWN) << CFG_SCLR_SEL) | 32'h4, RESP_OKAY);
		@(posedge clk);
		elemClr <= 6'h08;
		#2;
		check("sclr not yet", 34'(pinOut[3]), 34'h0);
		@(posedge clk);
		#2;
		check("sclr applied", 34'(pinOut[3]), 34'h1);
		@(posedge clk);
		elemClr <= 6'h00;
		$display("test enables and clear done");
		complete_run();
	end
endmodule // dio_col_block_tb_top
